// *** src/capture_compare_defs.vh ***
// Purpose: Constants for the capture/compare unit
// Assumes: Avalon-MM word addressing, 32-bit data, 8-bit registers in low bits
// Notes:   Definitions only
`ifndef CAPTURE_COMPARE_DEFS_VH
`define CAPTURE_COMPARE_DEFS_VH

// Register indices (byte address is four times the index)
`define CC_IDX_FLAGS      8'h0c
`define CC_IDX_ENABLE     8'h8c
`define CC_IDX_VALUE_LOW  8'h15
`define CC_IDX_VALUE_HIGH 8'h16
`define CC_IDX_CONTROL    8'h17
`define CC_IDX_STATUS     8'h18

// Control register layout
`define CC_CTRL_MASK      8'h3f
`define CC_CTRL_RESET     8'h00
`define CC_MODE_MSB       3
`define CC_MODE_LSB       0
`define CC_DUTY_MSB       5
`define CC_DUTY_LSB       4

// Flag and enable bit position
`define CC_FLAG_BIT       2

// Mode codes
`define CC_MODE_OFF       4'h0
`define CC_MODE_CAP_FALL  4'h4
`define CC_MODE_CAP_RISE  4'h5
`define CC_MODE_CAP_4     4'h6
`define CC_MODE_CAP_16    4'h7
`define CC_MODE_CMP_SET   4'h8
`define CC_MODE_CMP_CLR   4'h9
`define CC_MODE_CMP_SOFT  4'ha
`define CC_MODE_CMP_TRIG  4'hb

// Prescaler terminal counts
`define CC_PRE_4_LAST     4'h3
`define CC_PRE_16_LAST    4'hf
`define CC_PRE_STEP       4'h1
`define CC_PRE_CLEAR      4'h0

// Mode classes, taken from the two top bits of the mode field
`define CC_CLASS_CAPTURE  2'b01
`define CC_CLASS_COMPARE  2'b10
`define CC_CLASS_PWM      2'b11

`endif

// *** src/capture_compare_unit.v ***
// Purpose: Capture/compare unit with 16-bit stored value and mode-control register
// Assumes: First timer count arrives synchronous to clk_sys; pin level is asynchronous
// Notes:   PWM datapath lives elsewhere; this unit only exports the mode and duty bits
`default_nettype none
`include "capture_compare_defs.vh"

module capture_compare_unit (
  input  wire        clk_sys,              // System clock, 50 MHz
  input  wire        resetn,               // Synchronous reset, active low
  input  wire [7:0]  avs_address,          // Register index
  input  wire        avs_read,             // Read request
  input  wire        avs_write,            // Write request
  input  wire [31:0] avs_writedata,        // Write data
  input  wire [3:0]  avs_byteenable,       // Byte lanes
  output reg  [31:0] avs_readdata,         // Read data
  output wire        avs_waitrequest,      // Stall until answer ready
  output reg         avs_response_err,     // Unmapped access marker, with answer
  input  wire        unit_pin_in,          // Pad level of the unit pin
  output wire        unit_pin_out,         // Compare output latch
  output wire        unit_pin_oe_n,        // Low while compare mode drives pin
  input  wire [15:0] first_timer_count,    // First timer count
  input  wire        first_timer_tick,     // Count updated this cycle
  output reg         special_trigger,      // Clears first timer, starts conversion
  output wire [3:0]  unit_mode_select,     // Mode field for PWM logic
  output wire [1:0]  duty_low_bits,        // PWM duty two low bits
  output wire        pwm_mode_active,      // PWM logic uses second timer
  output wire        unit_event_flag,      // Sticky event flag
  output wire        unit_event_enable     // Software enable for that flag
);

  reg  [7:0]  control_q;
  reg  [7:0]  value_low_q;
  reg  [7:0]  value_high_q;
  reg         flag_q;
  reg         enable_q;
  reg         out_latch_q;
  reg  [3:0]  prescale_q;
  reg         pin_meta_q;
  reg         pin_sync_q;
  reg         pin_prev_q;
  reg         ack_q;
  reg         matched_q;

  // Theory of operation
  //
  // The unit holds one 16-bit value, split into a low and a high byte,
  // and one mode-control byte. The top two bits of the mode-control byte
  // are not stored at all, so they can never read back as anything but
  // zero. The next two bits are only carried to the PWM logic, which
  // lives outside this block; capture and compare ignore them.
  //
  // The low nibble selects the mode. Zero switches everything off: the
  // prescaler is cleared and the compare output latch returns to low.
  // The flag and the stored value are left alone, since software owns
  // them and a mode change must not lose a captured count.
  //
  // Capture modes watch the pad through a two-stage synchroniser and a
  // third history flop. An edge is seen two to three cycles after the
  // pad moves. The pad is watched whatever its direction, so software
  // that drives the pin itself can cause a capture; that is wanted.
  //
  // The prescaler counts rising edges in every capture mode, including
  // the falling-edge mode, where the count is simply unused. It is
  // cleared only outside capture modes. A direct switch between two
  // capture codes therefore keeps the count, and the first capture
  // after such a switch may come early. Software that cares writes
  // zero first and then the new code.
  //
  // Compare modes look at the timer count only when the timer reports
  // an update. Matching on every cycle would let one count that stays
  // put for many cycles raise the flag again and again; checking on
  // the update makes one match per count.
  //
  // Every match or capture raises the sticky flag. A software clear in
  // the same cycle as a hardware set loses, so no event is ever missed.
  // The cost is that software may see the flag still set after clearing
  // it, and must read it back if it needs to know.
  //
  // The register bus inserts exactly one wait state. The request is
  // taken in the first cycle, where read data is registered. In the
  // second cycle waitrequest drops, and a write takes effect at that
  // edge only. Read data is thus a flop output, never a mux of live
  // state, which keeps the bus timing path short.
  //
  // Unmapped indices answer with the error marker and no side effect.
  // The status index is read-only, so a write there counts as unmapped.
  //
  // Limitation: the timer must count on this same clock. A timer that
  // counts on another clock would need its own synchroniser, which this
  // unit does not provide.

  // Register strobes; a write lands only at the edge where waitrequest is low
  wire        sel_flags;
  wire        sel_enable;
  wire        sel_low;
  wire        sel_high;
  wire        sel_control;
  wire        sel_status;
  wire        sel_known;
  wire        wr_land;
  wire [3:0]  mode        = control_q[`CC_MODE_MSB:`CC_MODE_LSB];
  wire        is_capture  = (mode[3:2] == `CC_CLASS_CAPTURE);
  wire        is_compare  = (mode[3:2] == `CC_CLASS_COMPARE);
  wire        rise        = pin_sync_q & ~pin_prev_q;
  wire        fall        = ~pin_sync_q & pin_prev_q;
  wire        wr_go       = avs_write & ~ack_q;
  wire        rd_go       = avs_read & ~ack_q;
  wire        wr_lane0    = wr_land & avs_byteenable[0];
  wire [7:0]  wbyte       = avs_writedata[7:0];
  wire [15:0] stored_value = {value_high_q, value_low_q};
  reg         cap_event;
  wire        match       = is_compare & first_timer_tick & (first_timer_count == stored_value);

  // Address decode shared by the write strobes and the write error marker; the read mux cases on avs_address itself
  assign sel_flags   = (avs_address == `CC_IDX_FLAGS);
  assign sel_enable  = (avs_address == `CC_IDX_ENABLE);
  assign sel_low     = (avs_address == `CC_IDX_VALUE_LOW);
  assign sel_high    = (avs_address == `CC_IDX_VALUE_HIGH);
  assign sel_control = (avs_address == `CC_IDX_CONTROL);
  assign sel_status  = (avs_address == `CC_IDX_STATUS);
  assign sel_known   = sel_flags | sel_enable | sel_low | sel_high | sel_control;

  // Write lands in the answer cycle, when the master sees waitrequest low
  assign wr_land = avs_write & ack_q;

  // One wait cycle then answer; keeps readdata a flop
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

  assign unit_mode_select  = mode;
  assign duty_low_bits     = control_q[`CC_DUTY_MSB:`CC_DUTY_LSB];
  assign pwm_mode_active   = (mode[3:2] == `CC_CLASS_PWM);
  assign unit_event_flag   = flag_q;
  assign unit_event_enable = enable_q;
  assign unit_pin_out      = out_latch_q;
  assign unit_pin_oe_n     = ~is_compare;

  // Pin synchroniser and edge history; pad is watched in any direction
  always @(posedge clk_sys) begin
    if (!resetn) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= unit_pin_in;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // Capture event selection, including the rising-edge prescaler terminal count
  always @* begin
    case (mode)
      `CC_MODE_CAP_FALL: cap_event = fall;
      `CC_MODE_CAP_RISE: cap_event = rise;
      `CC_MODE_CAP_4:    cap_event = rise & (prescale_q[1:0] == `CC_PRE_4_LAST);
      `CC_MODE_CAP_16:   cap_event = rise & (prescale_q == `CC_PRE_16_LAST);
      default:           cap_event = 1'b0;
    endcase
  end

  // Prescaler: counts rising edges only while in a capture mode.
  // Switching between capture codes leaves the count alone, so the
  // first capture after such a switch may come early.
  always @(posedge clk_sys) begin
    if (!resetn) begin
      prescale_q <= `CC_PRE_CLEAR;
    end else if (!is_capture) begin
      prescale_q <= `CC_PRE_CLEAR;
    end else if (rise) begin
      prescale_q <= prescale_q + `CC_PRE_STEP;
    end
  end

  // Control register; top bits never stored
  always @(posedge clk_sys) begin
    if (!resetn) begin
      control_q <= `CC_CTRL_RESET;
    end else if (wr_lane0 && sel_control) begin
      control_q <= wbyte & `CC_CTRL_MASK;
    end
  end

  // Stored value: software writes, capture overwrites with no overrun record
  always @(posedge clk_sys) begin
    if (!resetn) begin
      value_low_q  <= 8'h00;
      value_high_q <= 8'h00;
    end else if (cap_event) begin
      value_low_q  <= first_timer_count[7:0];
      value_high_q <= first_timer_count[15:8];
    end else begin
      // Bytes are independent; no latching of one half on access to the other
      if (wr_lane0 && sel_low)
        value_low_q <= wbyte;
      if (wr_lane0 && sel_high)
        value_high_q <= wbyte;
    end
  end

  // Event flag: hardware set wins over a software clear in the same cycle.
  // A mode change may raise it spuriously; software clears it afterwards.
  always @(posedge clk_sys) begin
    if (!resetn) begin
      flag_q   <= 1'b0;
      enable_q <= 1'b0;
    end else begin
      if (cap_event || match)
        flag_q <= 1'b1;
      else if (wr_lane0 && sel_flags)
        flag_q <= wbyte[`CC_FLAG_BIT];
      // Enable only gates a downstream interrupt; it never masks the flag itself
      if (wr_lane0 && sel_enable)
        enable_q <= wbyte[`CC_FLAG_BIT];
    end
  end

  // Compare output latch and special event trigger
  always @(posedge clk_sys) begin
    if (!resetn) begin
      out_latch_q     <= 1'b0;
      special_trigger <= 1'b0;
      matched_q       <= 1'b0;
    end else begin
      special_trigger <= match && (mode == `CC_MODE_CMP_TRIG);
      matched_q       <= match;
      if (mode == `CC_MODE_OFF)
        out_latch_q <= 1'b0;
      else if (match && mode == `CC_MODE_CMP_SET)
        out_latch_q <= 1'b1;
      else if (match && mode == `CC_MODE_CMP_CLR)
        out_latch_q <= 1'b0;
    end
  end

  // Bus answer: one wait cycle, then read data with the waitrequest drop
  always @(posedge clk_sys) begin
    if (!resetn) begin
      ack_q            <= 1'b0;
      avs_readdata     <= 32'h0000_0000;
      avs_response_err <= 1'b0;
    end else begin
      ack_q            <= rd_go | wr_go;
      avs_response_err <= 1'b0;
      if (rd_go) begin
        case (avs_address)
          `CC_IDX_FLAGS:      avs_readdata <= {29'h0, flag_q, 2'b00};
          `CC_IDX_ENABLE:     avs_readdata <= {29'h0, enable_q, 2'b00};
          `CC_IDX_VALUE_LOW:  avs_readdata <= {24'h0, value_low_q};
          `CC_IDX_VALUE_HIGH: avs_readdata <= {24'h0, value_high_q};
          `CC_IDX_CONTROL:    avs_readdata <= {24'h0, control_q & `CC_CTRL_MASK};
          `CC_IDX_STATUS:     avs_readdata <= {26'h0, matched_q, out_latch_q, prescale_q};
          default: begin
            avs_readdata     <= 32'h0000_0000;
            avs_response_err <= 1'b1;
          end
        endcase
      end else if (wr_go) begin
        // Status is read-only, so a write there is reported like an unmapped one
        avs_response_err <= ~sel_known;
      end
    end
  end

endmodule // capture_compare_unit
`default_nettype wire

// *** verification/capture_compare_unit_asserts.sv ***
// Purpose: Port assertions for the capture/compare unit
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to the design top below
`default_nettype none
module cc_checker (
  input wire logic       clk_sys,          // Clock
  input wire logic       resetn,           // Reset
  input wire logic       avs_write,        // Write
  input wire logic       avs_waitrequest,  // Stall
  input wire logic [7:0] avs_address,      // Index
  input wire logic       unit_pin_out,     // Latch
  input wire logic       unit_pin_oe_n,    // Drive enable
  input wire logic       first_timer_tick, // Count step
  input wire logic       special_trigger,  // Trigger
  input wire logic [3:0] unit_mode_select, // Mode
  input wire logic       pwm_mode_active,  // PWM base
  input wire logic       unit_event_flag   // Flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Only a completed write to the flag register may clear the flag
  wire clr_w = avs_write && !avs_waitrequest && avs_address == 8'h0c;
  // Trigger lasts exactly one cycle
  sequence s_pulse; special_trigger ##1 !special_trigger; endsequence
  // Three off cycles let the latch clear after the mode write lands
  a_off_quiet: assert property ((unit_mode_select == 4'h0) [*3] |-> !unit_pin_out && unit_pin_oe_n)
    else $error("pin active while off");
  a_set_high: assert property ($rose(unit_pin_out) |-> $past(unit_mode_select) == 4'h8 && unit_event_flag)
    else $error("latch rose outside set mode");
  a_clr_low: assert property ($fell(unit_pin_out) && unit_mode_select == 4'h9 |-> unit_event_flag)
    else $error("latch fell without flag");
  a_soft_keep: assert property (unit_mode_select inside {4'ha, 4'hb} && $stable(unit_mode_select)
    |-> $stable(unit_pin_out)) else $error("latch moved in flag-only mode");
  a_trig_cause: assert property ($rose(special_trigger) |-> $past(unit_mode_select) == 4'hb
    && $past(first_timer_tick)) else $error("trigger without match");
  a_trig_pulse: assert property ($rose(special_trigger) |-> s_pulse)
    else $error("trigger not one cycle");
  a_flag_sticky: assert property (unit_event_flag && !clr_w |=> unit_event_flag)
    else $error("flag dropped by itself");
  a_pwm_base: assert property (pwm_mode_active == (unit_mode_select[3:2] == 2'b11))
    else $error("time base select wrong");
endmodule // cc_checker
bind capture_compare_unit cc_checker cc_checker_i (.clk_sys(clk_sys), .resetn(resetn), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .avs_address(avs_address), .unit_pin_out(unit_pin_out),
  .unit_pin_oe_n(unit_pin_oe_n), .first_timer_tick(first_timer_tick), .special_trigger(special_trigger),
  .unit_mode_select(unit_mode_select), .pwm_mode_active(pwm_mode_active), .unit_event_flag(unit_event_flag));
`default_nettype wire

// *** verification/pin_source_model.sv ***
// Purpose: Signal source on the unit pin
// Assumes: Pad level resolved from the unit's drive enable
// Notes:   Slow setting holds each new level back three cycles
`default_nettype none
module pin_source_model (
  input  wire logic clk_sys,       // Clock
  input  wire logic level,         // Wanted level
  input  wire logic slow,          // Late answer
  input  wire logic unit_pin_out,  // Unit drive
  input  wire logic unit_pin_oe_n, // Low while unit drives
  output wire logic pad            // Pad level
);
  logic [2:0] dly_q;
  // Source only drives while the unit leaves the pin as input
  always @(posedge clk_sys) dly_q <= {dly_q[1:0], level};
  assign pad = !unit_pin_oe_n ? unit_pin_out : (slow ? dly_q[2] : dly_q[0]);
endmodule // pin_source_model
`default_nettype wire

// *** verification/capture_compare_unit_tb_top.sv ***
// Purpose: Self-checking bench for the capture/compare unit
// Assumes: One wait state per register access
// Notes:   Reads queue their expectation; a monitor compares answers
`default_nettype none
module capture_compare_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, resetn, rd, wr, rerr, wreq, pad, pin_out, oe_n, tick, trig, pwm, flag, level, slow;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [15:0] cnt, a_val, b_val;
  logic [3:0]  mode;
  logic [1:0]  duty;
  logic [32:0] exp_q[$];
  int          err_total, tests_run;
  int          n_ev[4] = '{1, 1, 4, 16};
  logic [3:0]  cmp_m[4] = '{4'h8, 4'ha, 4'h9, 4'hb};
  capture_compare_unit capture_compare_unit_i (.clk_sys(clk_sys), .resetn(resetn), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .avs_response_err(rerr), .unit_pin_in(pad), .unit_pin_out(pin_out),
    .unit_pin_oe_n(oe_n), .first_timer_count(cnt), .first_timer_tick(tick), .special_trigger(trig),
    .unit_mode_select(mode), .duty_low_bits(duty), .pwm_mode_active(pwm), .unit_event_flag(flag),
    .unit_event_enable());
  pin_source_model pin_source_model_i (.clk_sys(clk_sys), .level(level), .slow(slow), .unit_pin_out(pin_out),
    .unit_pin_oe_n(oe_n), .pad(pad));
  // Timer moves only on ticks or a trigger clear, so the bench may load it when idle
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (trig || tick) cnt <= trig ? 16'h0000 : cnt + 16'h0001;
  // Each read answer takes the oldest note off the queue
  always @(posedge clk_sys) if (rd && !wreq) chk(exp_q.pop_front(), {rerr, rdata});
  task automatic chk(input logic [32:0] e, input logic [32:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic end_sim;
    $display("counts: %0d compares, %0d mismatches", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Read notes v as expectation; write sends v; one idle edge keeps strobes clean
  task automatic bus(input logic w, input logic [7:0] a, input logic [32:0] v);
    int n;
    n = 0;
    if (!w) exp_q.push_back(v);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= v[31:0];
    @(posedge clk_sys);
    while (wreq) begin
      @(posedge clk_sys);
      n++;
      if (n > 20) begin
        err_total++;
        end_sim;
      end
    end
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Pad change plus room for synchroniser and capture
  task automatic pin(input logic l);
    level <= l;
    repeat (10) @(posedge clk_sys);
  endtask
  initial begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    {rd, wr, tick, level, slow, addr, wdata, cnt} = '0;
    err_total = 0;
    tests_run = 0;
    void'($urandom(32'haccae7ce));
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    bus(1'b0, 8'h17, 33'h0); // Control reset value
    bus(1'b0, 8'h01, 33'h100000000);
    bus(1'b1, 8'h17, 33'hff);
    bus(1'b0, 8'h17, 33'h3f); // Top bits read zero
    chk(33'(duty), 33'h3); // Duty low bits
    chk(33'(pwm), 33'h1); // PWM code uses second timer
    chk(33'(mode), 33'hf); // Mode field exported
    bus(1'b1, 8'h8c, 33'h4); // Enable bit
    bus(1'b0, 8'h8c, 33'h4); // Enable reads back
    chk(33'(capture_compare_unit_i.unit_event_enable), 33'h1); // Enable output
    bus(1'b1, 8'h8c, 33'h0); // Keep enable clear during mode changes
    // Capture modes: prescaled edges leave the flag clear until the last one
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h17, 33'h0); // Off clears prescaler
      bus(1'b1, 8'h17, 33'(4 + i));
      slow <= 1'($urandom_range(1, 0));
      pin(i == 0);
      bus(1'b1, 8'h0c, 33'h0); // Clear false flag
      a_val = 16'($urandom);
      cnt <= a_val;
      repeat (n_ev[i] - 1) begin
        pin(i != 0);
        pin(i == 0);
      end
      bus(1'b0, 8'h0c, 33'h0); // No early capture
      b_val = 16'($urandom);
      cnt <= b_val;
      pin(i != 0);
      bus(1'b0, 8'h0c, 33'h4); // Flag set
      bus(1'b0, 8'h15, {25'h0, b_val[7:0]}); // Newest count wins
      bus(1'b0, 8'h16, {25'h0, b_val[15:8]}); // High byte
    end
    // Compare modes run the timer until the match flag shows
    a_val = 16'h0010 + 16'($urandom_range(200, 0));
    bus(1'b1, 8'h15, {25'h0, a_val[7:0]});
    bus(1'b1, 8'h16, 33'h0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h17, {29'h0, cmp_m[i]});
      bus(1'b1, 8'h0c, 33'h0);
      cnt <= 16'h0000;
      tick <= 1'b1;
      for (int n = 0; flag !== 1'b1; n++) begin
        @(posedge clk_sys);
        if (n > 600) begin
          err_total++;
          end_sim;
        end
      end
      tick <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk(33'(pin_out), 33'(i < 2)); // Pin per mode
      if (i == 3) chk(33'(cnt < a_val), 33'h1); // Timer cleared
      if (i == 0) bus(1'b0, 8'h18, 33'h10); // Status shows latch high
    end
    end_sim;
  end
endmodule // capture_compare_unit_tb_top
`default_nettype wire
